// file: logic/lamp_supervisor_map.svh
// Constant map for the lamp strike/run fault supervisor
`ifndef LAMP_SUPERVISOR_MAP_SVH
`define LAMP_SUPERVISOR_MAP_SVH

// Clock rate in kHz
`define SUP_CLK_KHZ           25000
// Error amp discharge time after an over-voltage event, ns
`define SUP_DISCHARGE_NS      600
// Discharge length in cycles, rounded down, at least one
`define SUP_DISCHARGE_CYC     ((`SUP_DISCHARGE_NS * `SUP_CLK_KHZ) / 1000000)
// Strike timeout, ms (nominal figure inside the 1 - 2 s band)
`define SUP_STRIKE_MS         1400
`define SUP_STRIKE_CYC        (`SUP_STRIKE_MS * `SUP_CLK_KHZ)
// Counter widths
`define SUP_EVENT_BITS        4
`define SUP_OPEN_WD_BITS      9
`define SUP_SHORT_WD_BITS     7
`define SUP_DISCHARGE_BITS    5

`endif

// file: logic/lamp_supervisor_pkg.sv
// Types for the lamp strike/run fault supervisor
`default_nettype none
package lamp_supervisor_pkg;

   typedef enum logic [2:0] {
      ST_OFF    = 3'b001,
      ST_STRIKE = 3'b010,
      ST_RUN    = 3'b100
   } mode_t;

   typedef enum logic [2:0] {
      FAULT_NONE       = 3'h0,
      FAULT_STRIKE_TO  = 3'h1,
      FAULT_OVER_VOLT  = 3'h2,
      FAULT_OVER_CURR  = 3'h3,
      FAULT_OPEN_LAMP  = 3'h4,
      FAULT_SHORT_LAMP = 3'h5
   } fault_t;

endpackage

`default_nettype wire

// file: logic/sync_two_stage.sv
// Two flip-flop synchroniser for one comparator level
`timescale 1ns/1ps
`default_nettype none

module sync_two_stage (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic async_in,
   output var  logic sync_out
);

   logic meta;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         meta     <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule

`default_nettype wire

// file: logic/lamp_supervisor.sv
// Strike/run sequencer and fault supervisor for a resonant full-bridge lamp drive
// How it works
// - Power-up or enable rising enters strike mode.
// - Detected ignition moves strike mode to run mode.
// - Current peak above 1.0V during strike sets the ignition latch.
// - Strike timeout without ignition latches a fault, outputs off.
// - In run mode the current comparison level drops to 0.3V.
// - Strike starts at programmed frequency; tracking sweeps after first zero crossing.
// - Strike uses tracking loop; ignition hands control to fixed oscillator.
// - Before ignition in strike, clamp error amp output to 2.5V.
// - Latched faults clear only by enable or driver supply cycling.
// - Sixteen over-voltage peaks above 3.2V latch an over-voltage fault.
// - Over-voltage counting runs in strike and run modes only.
// - Each burst ramp cycle clears the shared event counter.
// - Over-voltage forces error amp discharge for about 600ns.
// - Run mode current peaks above 0.3V reset 9-bit watchdog; overflow faults.
// - Voltage peaks below 0.7V block 7-bit short counter reset; overflow faults.
// - Short-lamp detection works in both strike and run modes.
// - Short-lamp detection waits until timeout capacitor exceeds 0.5V.
// - In run mode, short counter holds during dimming off time.
// - Failed ignition or lamp loss shuts down without outside help.
// - Return current peaks above 2.0V clock the shared event counter.
// - Analog supply undervoltage holds all gate drives inactive.
`timescale 1ns/1ps
`default_nettype none
`include "lamp_supervisor_map.svh"

module lamp_supervisor #(
   parameter int unsigned STRIKE_CYCLES = `SUP_STRIKE_CYC
) (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       enable,
   input  wire logic       driver_supply_ok,
   input  wire logic       analog_supply_uvlo,
   input  wire logic       lamp_current_sense_above_strike,
   input  wire logic       lamp_current_sense_above_run,
   input  wire logic       lamp_voltage_sense_node_above_trip,
   input  wire logic       lamp_voltage_sense_node_above_short,
   input  wire logic       lamp_voltage_sense_node_zero_cross,
   input  wire logic       ocsns_above_trip,
   input  wire logic       burst_ramp_signal,
   input  wire logic       dim_off_interval,
   input  wire logic       timeout_cap_above_en,
   input  wire logic       osc_phase_a,
   input  wire logic       osc_phase_b,
   output var  logic       gate_a,
   output var  logic       gate_b,
   output var  logic       gate_c,
   output var  logic       gate_d,
   output var  logic       strike_mode,
   output var  logic       run_mode,
   output var  logic       use_tracking_osc,
   output var  logic       tracking_sweep,
   output var  logic       run_threshold_sel,
   output var  logic       error_amp_clamp,
   output var  logic       error_amp_discharge,
   output var  logic       fault_latched,
   output var  logic [2:0] fault_cause
);

   localparam int unsigned DIS_RAW = `SUP_DISCHARGE_CYC;
   localparam int unsigned DIS_CYC = (DIS_RAW < 1) ? 1 : DIS_RAW;
   localparam int unsigned EVW = `SUP_EVENT_BITS;
   localparam int unsigned OWW = `SUP_OPEN_WD_BITS;
   localparam int unsigned SWW = `SUP_SHORT_WD_BITS;
   localparam int unsigned DSW = `SUP_DISCHARGE_BITS;

   // ==========================================================
   // Input synchronisers
   // ==========================================================
   localparam int unsigned NSYNC = 14;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] sy;

   assign raw_in = {enable, driver_supply_ok, analog_supply_uvlo, lamp_current_sense_above_strike,
                    lamp_current_sense_above_run, lamp_voltage_sense_node_above_trip, lamp_voltage_sense_node_above_short,
                    lamp_voltage_sense_node_zero_cross, ocsns_above_trip, burst_ramp_signal,
                    dim_off_interval, timeout_cap_above_en, osc_phase_a,
                    osc_phase_b};

   for (genvar i = 0; i < NSYNC; i++) begin : g_sync
      sync_two_stage u_sync (
         .sys_clk  (sys_clk),
         .rst      (rst),
         .async_in (raw_in[i]),
         .sync_out (sy[i])
      );
   end

   logic s_en, s_driver_supply, s_uvlo, s_i_strk, s_i_run, s_ov, s_ov_short;
   logic s_zero, s_oc, s_burst, s_dim_off, s_to_en, s_pa, s_pb;
   assign {s_en, s_driver_supply, s_uvlo, s_i_strk, s_i_run, s_ov, s_ov_short,
           s_zero, s_oc, s_burst, s_dim_off, s_to_en, s_pa, s_pb} = sy;

   // ==========================================================
   // Edge detection on synchronised levels
   // ==========================================================
   logic d_en, d_driver_supply, d_i_strk, d_i_run, d_ov, d_oc, d_burst, d_ov_short;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         d_en       <= 1'b0;
         d_driver_supply     <= 1'b0;
         d_i_strk   <= 1'b0;
         d_i_run    <= 1'b0;
         d_ov       <= 1'b0;
         d_oc       <= 1'b0;
         d_burst    <= 1'b0;
         d_ov_short <= 1'b0;
      end else begin
         d_en       <= s_en;
         d_driver_supply     <= s_driver_supply;
         d_i_strk   <= s_i_strk;
         d_i_run    <= s_i_run;
         d_ov       <= s_ov;
         d_oc       <= s_oc;
         d_burst    <= s_burst;
         d_ov_short <= s_ov_short;
      end
   end

   logic powered, start_req, ov_pulse, oc_pulse, burst_pulse;
   logic strike_peak, run_peak, short_peak;
   assign powered     = s_en && s_driver_supply;
   // Enable rising or driver supply returning both restart a strike
   assign start_req   = powered && !(d_en && d_driver_supply);
   assign ov_pulse    = s_ov && !d_ov;
   assign oc_pulse    = s_oc && !d_oc;
   assign burst_pulse = s_burst && !d_burst;
   assign strike_peak = s_i_strk && !d_i_strk;
   assign run_peak    = s_i_run && !d_i_run;
   assign short_peak  = s_ov_short && !d_ov_short;

   // ==========================================================
   // Mode state machine and fault latch
   // ==========================================================
   lamp_supervisor_pkg::mode_t  mode;
   lamp_supervisor_pkg::mode_t  next_mode;
   lamp_supervisor_pkg::fault_t next_cause;
   logic                        fault_hit;
   logic                        strike_to_hit;
   logic                        ov_hit;
   logic                        oc_hit;
   logic                        open_hit;
   logic                        short_hit;

   assign fault_hit = strike_to_hit || ov_hit || oc_hit || open_hit || short_hit;

   always_comb begin
      next_cause = lamp_supervisor_pkg::FAULT_NONE;
      if (strike_to_hit)
         next_cause = lamp_supervisor_pkg::FAULT_STRIKE_TO;
      else if (ov_hit)
         next_cause = lamp_supervisor_pkg::FAULT_OVER_VOLT;
      else if (oc_hit)
         next_cause = lamp_supervisor_pkg::FAULT_OVER_CURR;
      else if (open_hit)
         next_cause = lamp_supervisor_pkg::FAULT_OPEN_LAMP;
      else if (short_hit)
         next_cause = lamp_supervisor_pkg::FAULT_SHORT_LAMP;
   end

   always_comb begin
      next_mode = mode;
      unique case (mode)
         lamp_supervisor_pkg::ST_OFF: begin
            if (start_req)
               next_mode = lamp_supervisor_pkg::ST_STRIKE;
         end
         lamp_supervisor_pkg::ST_STRIKE: begin
            if (!powered || fault_hit)
               next_mode = lamp_supervisor_pkg::ST_OFF;
            else if (strike_peak)
               next_mode = lamp_supervisor_pkg::ST_RUN;
         end
         lamp_supervisor_pkg::ST_RUN: begin
            if (!powered || fault_hit)
               next_mode = lamp_supervisor_pkg::ST_OFF;
         end
         default: next_mode = lamp_supervisor_pkg::ST_OFF;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst)
         mode <= lamp_supervisor_pkg::ST_OFF;
      else if (fault_latched && !start_req)
         mode <= lamp_supervisor_pkg::ST_OFF;
      else
         mode <= next_mode;
   end

   // Only an enable or supply restart clears it
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fault_latched <= 1'b0;
         fault_cause   <= lamp_supervisor_pkg::FAULT_NONE;
      end else if (fault_hit && !fault_latched) begin
         fault_latched <= 1'b1;
         fault_cause   <= next_cause;
      end else if (start_req) begin
         fault_latched <= 1'b0;
         fault_cause   <= lamp_supervisor_pkg::FAULT_NONE;
      end
   end

   logic active;
   assign active = (mode != lamp_supervisor_pkg::ST_OFF) && !fault_latched;

   // ==========================================================
   // Strike timer
   // ==========================================================
   logic [31:0] strike_cnt;

   always_ff @(posedge sys_clk) begin
      if (rst || mode != lamp_supervisor_pkg::ST_STRIKE)
         strike_cnt <= 32'h0;
      else if (strike_cnt < STRIKE_CYCLES)
         strike_cnt <= strike_cnt + 32'h1;
   end

   assign strike_to_hit = active && mode == lamp_supervisor_pkg::ST_STRIKE
                          && strike_cnt >= STRIKE_CYCLES && !strike_peak;

   // ==========================================================
   // Shared over-voltage / over-current event counter
   // ==========================================================
   logic [EVW-1:0] event_cnt;
   logic           event_in;
   assign event_in = ov_pulse || oc_pulse;

   always_ff @(posedge sys_clk) begin
      if (rst || burst_pulse || !active)
         event_cnt <= '0;
      else if (event_in)
         event_cnt <= event_cnt + EVW'(1);
   end

   // Sixteenth event is the one arriving with the counter full
   assign ov_hit = active && ov_pulse && !burst_pulse && (&event_cnt);
   assign oc_hit = active && oc_pulse && !ov_pulse && !burst_pulse
                   && (&event_cnt);

   // ==========================================================
   // Open-lamp watchdog, run mode
   // ==========================================================
   logic [OWW-1:0] open_cnt;

   always_ff @(posedge sys_clk) begin
      if (rst || mode != lamp_supervisor_pkg::ST_RUN || run_peak)
         open_cnt <= '0;
      else
         open_cnt <= open_cnt + OWW'(1);
   end

   assign open_hit = active && mode == lamp_supervisor_pkg::ST_RUN
                     && (&open_cnt) && !run_peak;

   // ==========================================================
   // Shorted-lamp watchdog
   // ==========================================================
   logic [SWW-1:0] short_cnt;
   logic           short_hold;
   // Dimming off time would look like a short, so the count waits
   assign short_hold = mode == lamp_supervisor_pkg::ST_RUN && s_dim_off;

   always_ff @(posedge sys_clk) begin
      if (rst || !active || !s_to_en || short_peak)
         short_cnt <= '0;
      else if (!short_hold)
         short_cnt <= short_cnt + SWW'(1);
   end

   assign short_hit = active && s_to_en && !short_hold && !short_peak
                      && (&short_cnt);

   // ==========================================================
   // Oscillator selection and error amp control
   // ==========================================================
   logic seen_zero;

   always_ff @(posedge sys_clk) begin
      if (rst || mode != lamp_supervisor_pkg::ST_STRIKE)
         seen_zero <= 1'b0;
      else if (s_zero)
         seen_zero <= 1'b1;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         strike_mode       <= 1'b0;
         run_mode          <= 1'b0;
         use_tracking_osc  <= 1'b0;
         tracking_sweep    <= 1'b0;
         run_threshold_sel <= 1'b0;
         error_amp_clamp   <= 1'b0;
      end else begin
         strike_mode       <= next_mode == lamp_supervisor_pkg::ST_STRIKE && !fault_hit;
         run_mode          <= next_mode == lamp_supervisor_pkg::ST_RUN && !fault_hit;
         use_tracking_osc  <= next_mode == lamp_supervisor_pkg::ST_STRIKE;
         tracking_sweep    <= next_mode == lamp_supervisor_pkg::ST_STRIKE
                              && (seen_zero || s_zero);
         run_threshold_sel <= next_mode == lamp_supervisor_pkg::ST_RUN;
         error_amp_clamp   <= next_mode == lamp_supervisor_pkg::ST_STRIKE;
      end
   end

   logic [DSW-1:0] dis_cnt;

   always_ff @(posedge sys_clk) begin
      if (rst)
         dis_cnt <= '0;
      else if (s_ov)
         dis_cnt <= DSW'(DIS_CYC);
      else if (dis_cnt != '0)
         dis_cnt <= dis_cnt - DSW'(1);
   end

   always_ff @(posedge sys_clk) begin
      if (rst)
         error_amp_discharge <= 1'b0;
      else
         error_amp_discharge <= s_ov || dis_cnt > DSW'(1);
   end

   // ==========================================================
   // Gate drives
   // ==========================================================
   logic drive_ok;
   // Undervoltage and any fault kill all four drives at once
   assign drive_ok = active && !fault_hit && !s_uvlo && next_mode != lamp_supervisor_pkg::ST_OFF;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         gate_a <= 1'b0;
         gate_b <= 1'b0;
         gate_c <= 1'b0;
         gate_d <= 1'b0;
      end else begin
         gate_a <= drive_ok && s_pa && !s_pb;
         gate_b <= drive_ok && s_pb && !s_pa;
         gate_c <= drive_ok && s_pb && !s_pa;
         gate_d <= drive_ok && s_pa && !s_pb;
      end
   end

endmodule

`default_nettype wire

// file: sim/lamp_supervisor_monitor.sv
// Port-level assertions for the lamp strike/run fault supervisor
`timescale 1ns/1ps
`default_nettype none

module lamp_supervisor_monitor #(
   parameter int unsigned STRIKE_CYCLES = 200
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic driver_supply_ok,
   input wire logic analog_supply_uvlo,
   input wire logic lamp_current_sense_above_strike,
   input wire logic lamp_voltage_sense_node_above_trip,
   input wire logic lamp_voltage_sense_node_zero_cross,
   input wire logic ocsns_above_trip,
   input wire logic burst_ramp_signal,
   input wire logic gate_a,
   input wire logic gate_b,
   input wire logic gate_c,
   input wire logic gate_d,
   input wire logic strike_mode,
   input wire logic run_mode,
   input wire logic use_tracking_osc,
   input wire logic tracking_sweep,
   input wire logic run_threshold_sel,
   input wire logic error_amp_clamp,
   input wire logic error_amp_discharge,
   input wire logic fault_latched
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // ==========================================
   // Helper counters
   logic [3:0]  up_cnt;
   logic [4:0]  ev_cnt;
   int unsigned strk_cnt;
   wire         any_gate = gate_a | gate_b | gate_c | gate_d;

   always_ff @(posedge sys_clk) begin
      if (rst || !enable || !driver_supply_ok) begin
         up_cnt <= 4'h0;
      end else if (up_cnt != 4'hF) begin
         up_cnt <= up_cnt + 4'h1;
      end
   end

   // Cleared on enable drop too, so an enable restart never inherits a stale count
   always_ff @(posedge sys_clk) begin
      if (rst || !enable || $rose(burst_ramp_signal)) begin
         ev_cnt <= 5'h00;
      end else if (($rose(lamp_voltage_sense_node_above_trip) || $rose(ocsns_above_trip)) && ev_cnt != 5'h1F) begin
         ev_cnt <= ev_cnt + 5'h01;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst || !strike_mode) begin
         strk_cnt <= 0;
      end else begin
         strk_cnt <= strk_cnt + 1;
      end
   end

   // ==========================================
   // Properties
   sequence s_ignite;
      strike_mode && enable && $rose(lamp_current_sense_above_strike);
   endsequence
   sequence s_zc_in_strike;
      (strike_mode && $rose(lamp_voltage_sense_node_zero_cross)) ##1 strike_mode[*4];
   endsequence

   property p_gates_fault;
      fault_latched |-> !any_gate && !strike_mode && !run_mode;
   endproperty
   a_gates_fault: assert property (p_gates_fault)
      else $error("gates or mode active under fault");
   property p_uvlo_off;
      analog_supply_uvlo[*4] |-> !any_gate;
   endproperty
   a_uvlo_off: assert property (p_uvlo_off)
      else $error("gate driven during undervoltage");
   property p_fault_hold;
      $fell(fault_latched) |-> up_cnt < 4'h8;
   endproperty
   a_fault_hold: assert property (p_fault_hold)
      else $error("fault cleared without enable cycle");
   property p_ignite;
      s_ignite |-> ##[1:5] (run_mode || fault_latched);
   endproperty
   a_ignite: assert property (p_ignite)
      else $error("ignition did not reach run mode");
   property p_run_cfg;
      run_mode |-> !use_tracking_osc && run_threshold_sel && !error_amp_clamp;
   endproperty
   a_run_cfg: assert property (p_run_cfg)
      else $error("run mode settings wrong");
   property p_strike_cfg;
      strike_mode |-> use_tracking_osc && error_amp_clamp && !run_threshold_sel;
   endproperty
   a_strike_cfg: assert property (p_strike_cfg)
      else $error("strike mode settings wrong");
   property p_discharge;
      $rose(lamp_voltage_sense_node_above_trip) |-> ##[1:4] error_amp_discharge ##1 error_amp_discharge[*8];
   endproperty
   a_discharge: assert property (p_discharge)
      else $error("discharge missing or short");
   property p_sweep;
      s_zc_in_strike |-> tracking_sweep;
   endproperty
   a_sweep: assert property (p_sweep)
      else $error("no sweep after zero crossing");
   property p_event_limit;
      ev_cnt == 5'h10 |-> ##[0:4] fault_latched;
   endproperty
   a_event_limit: assert property (p_event_limit)
      else $error("no fault after 16 events");
   property p_strike_limit;
      strike_mode |-> strk_cnt <= STRIKE_CYCLES + 4;
   endproperty
   a_strike_limit: assert property (p_strike_limit)
      else $error("strike outlived timeout");
endmodule

bind lamp_supervisor lamp_supervisor_monitor #(.STRIKE_CYCLES(STRIKE_CYCLES)) mon_u (
   .sys_clk, .rst, .enable, .driver_supply_ok, .analog_supply_uvlo, .lamp_current_sense_above_strike,
   .lamp_voltage_sense_node_above_trip, .lamp_voltage_sense_node_zero_cross, .ocsns_above_trip, .burst_ramp_signal,
   .gate_a, .gate_b, .gate_c, .gate_d, .strike_mode, .run_mode, .use_tracking_osc,
   .tracking_sweep, .run_threshold_sel, .error_amp_clamp, .error_amp_discharge, .fault_latched
);
`default_nettype wire

// file: sim/lamp_network_model.sv
// Behavioural bridge and lamp sense network facing the supervisor
`timescale 1ns/1ps
`default_nettype none

module lamp_network_model (
   input  wire logic sys_clk,
   input  wire logic gate_a,
   input  wire logic gate_b,
   input  wire logic lamp_lit,
   input  wire logic lamp_short,
   output var  logic lamp_current_sense_above_strike,
   output var  logic lamp_current_sense_above_run,
   output var  logic lamp_voltage_sense_node_above_short,
   output var  logic lamp_voltage_sense_node_zero_cross
);
   initial {lamp_current_sense_above_strike, lamp_current_sense_above_run, lamp_voltage_sense_node_above_short, lamp_voltage_sense_node_zero_cross} = 4'h0;

   // Sense peaks only exist while the bridge switches; a dead bridge gives no pulses
   always @(posedge sys_clk) begin
      lamp_current_sense_above_strike <= lamp_lit & gate_a;
      lamp_current_sense_above_run <= lamp_lit & gate_a;
      lamp_voltage_sense_node_above_short <= !lamp_short & gate_a;
      lamp_voltage_sense_node_zero_cross <= gate_b;
   end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the lamp strike/run fault supervisor
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   localparam int unsigned STRIKE_CYC = 400;
   typedef struct {int ov_a; int oc; logic burst; int ov_b; logic fault; logic [2:0] cause;} row_t;
   logic       sys_clk = 1'b0, rst = 1'b1, enable = 1'b0, driver_supply_ok = 1'b1;
   logic       analog_supply_uvlo = 1'b0, lamp_voltage_sense_node_above_trip = 1'b0, ocsns_above_trip = 1'b0;
   logic       burst_ramp_signal = 1'b0, dim_off_interval = 1'b0, timeout_cap_above_en = 1'b0;
   logic       osc_phase_a = 1'b0, osc_phase_b = 1'b0, lamp_lit = 1'b0, lamp_short = 1'b0;
   logic [2:0] phase_cnt = 3'h0;
   logic       lamp_current_sense_above_strike, lamp_current_sense_above_run, lamp_voltage_sense_node_above_short, lamp_voltage_sense_node_zero_cross;
   logic       gate_a, gate_b, gate_c, gate_d, strike_mode, run_mode, use_tracking_osc;
   logic       tracking_sweep, run_threshold_sel, error_amp_clamp, error_amp_discharge;
   logic       fault_latched;
   logic [2:0] fault_cause;
   int         fail_count = 0;
   int         tests_run = 0;
   row_t       rows [5];

   lamp_supervisor #(.STRIKE_CYCLES(STRIKE_CYC)) dut_u (
      .sys_clk, .rst, .enable, .driver_supply_ok, .analog_supply_uvlo, .lamp_current_sense_above_strike,
      .lamp_current_sense_above_run, .lamp_voltage_sense_node_above_trip, .lamp_voltage_sense_node_above_short, .lamp_voltage_sense_node_zero_cross,
      .ocsns_above_trip, .burst_ramp_signal, .dim_off_interval, .timeout_cap_above_en,
      .osc_phase_a, .osc_phase_b, .gate_a, .gate_b, .gate_c, .gate_d, .strike_mode, .run_mode,
      .use_tracking_osc, .tracking_sweep, .run_threshold_sel, .error_amp_clamp,
      .error_amp_discharge, .fault_latched, .fault_cause
   );
   lamp_network_model model_u (
      .sys_clk, .gate_a, .gate_b, .lamp_lit, .lamp_short, .lamp_current_sense_above_strike,
      .lamp_current_sense_above_run, .lamp_voltage_sense_node_above_short, .lamp_voltage_sense_node_zero_cross
   );

   always #20 sys_clk = ~sys_clk;

   // Non-overlapping oscillator phases, 8 cycles a period
   always @(posedge sys_clk) begin
      phase_cnt <= phase_cnt + 3'h1;
      osc_phase_a <= phase_cnt >= 3'h1 && phase_cnt <= 3'h3;
      osc_phase_b <= phase_cnt >= 3'h5;
   end

   // ==========================================
   // Tasks
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // Samples 1 ns after the edge, then waits for the next edge so stimulus stays on edges
   task automatic check(input string name, input logic [2:0] exp, input logic [2:0] got);
      #1;
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
      @(posedge sys_clk);
   endtask

   task automatic wrap_up();
      if (fail_count == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic burst();
      burst_ramp_signal <= 1'b1;
      tick(3);
      burst_ramp_signal <= 1'b0;
      tick(3);
   endtask

   task automatic restart();
      enable <= 1'b0;
      tick(4);
      enable <= 1'b1;
      tick(8);
      check("strike_mode", 3'h1, 3'(strike_mode));
      burst();
   endtask

   task automatic pulses(input int n, input logic ov, input logic oc);
      repeat (n) begin
         lamp_voltage_sense_node_above_trip <= ov;
         ocsns_above_trip <= oc;
         tick(2);
         lamp_voltage_sense_node_above_trip <= 1'b0;
         ocsns_above_trip <= 1'b0;
         tick(2);
      end
   endtask

   // ==========================================
   // Main sequence
   initial begin
      rows[0] = '{15, 0, 1'b0, 0, 1'b0, 3'h0};
      rows[1] = '{16, 0, 1'b0, 0, 1'b1, lamp_supervisor_pkg::FAULT_OVER_VOLT};
      rows[2] = '{0, 16, 1'b0, 0, 1'b1, lamp_supervisor_pkg::FAULT_OVER_CURR};
      rows[3] = '{10, 0, 1'b1, 10, 1'b0, 3'h0};
      rows[4] = '{8, 8, 1'b0, 0, 1'b1, lamp_supervisor_pkg::FAULT_OVER_CURR};
      tick(3);
      rst <= 1'b0;
      tick(2);
      check("strike_mode", 3'h0, 3'(strike_mode));
      foreach (rows[i]) begin
         restart();
         pulses(rows[i].ov_a, 1'b1, 1'b0);
         pulses(rows[i].oc, 1'b0, 1'b1);
         if (rows[i].burst) begin
            burst();
         end
         pulses(rows[i].ov_b, 1'b1, 1'b0);
         tick(6);
         // Discharge still stands 8 cycles after the last over-voltage pulse ends
         check("error_amp_discharge",
               3'(rows[i].ov_b > 0 || (rows[i].ov_a > 0 && rows[i].oc == 0)),
               3'(error_amp_discharge));
         check("fault_latched", 3'(rows[i].fault), 3'(fault_latched));
         if (!rows[i].fault || rows[i].cause != 3'h0) begin
            check("fault_cause", rows[i].cause, fault_cause);
         end
      end
      restart();
      tick(20);
      check("tracking_sweep", 3'h1, 3'(tracking_sweep));
      check("error_amp_clamp", 3'h1, 3'(error_amp_clamp));
      lamp_lit <= 1'b1;
      tick(20);
      check("run_mode", 3'h1, 3'(run_mode));
      check("run_threshold_sel", 3'h1, 3'(run_threshold_sel));
      check("use_tracking_osc", 3'h0, 3'(use_tracking_osc));
      repeat (8) begin
         check("gate_d", 3'(gate_a), 3'(gate_d));
         check("gate_c", 3'(gate_b), 3'(gate_c));
      end
      tick(700);
      check("fault_latched", 3'h0, 3'(fault_latched));
      timeout_cap_above_en <= 1'b1;
      dim_off_interval <= 1'b1;
      lamp_short <= 1'b1;
      tick(300);
      check("fault_latched", 3'h0, 3'(fault_latched));
      dim_off_interval <= 1'b0;
      tick(200);
      check("fault_cause", lamp_supervisor_pkg::FAULT_SHORT_LAMP, fault_cause);
      lamp_short <= 1'b0;
      tick(50);
      check("fault_latched", 3'h1, 3'(fault_latched));
      check("gates", 3'h0, 3'(gate_a | gate_b | gate_c | gate_d));
      driver_supply_ok <= 1'b0;
      tick(4);
      driver_supply_ok <= 1'b1;
      tick(30);
      check("run_mode", 3'h1, 3'(run_mode));
      lamp_lit <= 1'b0;
      tick(600);
      check("fault_cause", lamp_supervisor_pkg::FAULT_OPEN_LAMP, fault_cause);
      timeout_cap_above_en <= 1'b0;
      lamp_short <= 1'b1;
      restart();
      tick(150);
      check("fault_latched", 3'h0, 3'(fault_latched));
      timeout_cap_above_en <= 1'b1;
      tick(140);
      check("fault_cause", lamp_supervisor_pkg::FAULT_SHORT_LAMP, fault_cause);
      lamp_short <= 1'b0;
      timeout_cap_above_en <= 1'b0;
      restart();
      tick(STRIKE_CYC + 10);
      check("fault_cause", lamp_supervisor_pkg::FAULT_STRIKE_TO, fault_cause);
      restart();
      analog_supply_uvlo <= 1'b1;
      tick(5);
      repeat (8) begin
         check("gates", 3'h0, 3'(gate_a | gate_b | gate_c | gate_d));
         tick(1);
      end
      analog_supply_uvlo <= 1'b0;
      rst <= 1'b1;
      tick(3);
      rst <= 1'b0;
      tick(1);
      check("strike_mode", 3'h0, 3'(strike_mode));
      check("fault_latched", 3'h0, 3'(fault_latched));
      wrap_up();
   end

   initial begin
      #400000;
      fail_count++;
      wrap_up();
   end
endmodule
`default_nettype wire
